// [dv/fpet_flash_model.sv]
// Flash array model counting programmed block units
`timescale 1ns/1ps
module fpet_flash_model (
  input wire logic clk,
  input wire logic data_take,
  output int units
);
  initial units = 0;
  always @(posedge clk) if (data_take) units <= units + 1;
endmodule

// [dv/fpet_seq_asserts.sv]
// Assertion checker for the flash timer
`timescale 1ns/1ps
module fpet_seq_asserts #(
  parameter int DIV_W = 6
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] src_en,
  input wire logic src_sel,
  input wire logic [DIV_W-1:0] div_val,
  input wire logic req,
  input wire logic [2:0] op,
  input wire logic more,
  input wire logic busy,
  input wire logic prog,
  input wire logic erase,
  input wire logic mass,
  input wire logic data_take,
  input wire logic done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic go;
  logic fast;
  assign go = req && !busy && op inside {3'h1, 3'h2, 3'h3, 3'h4};
  assign fast = div_val == '0 && src_en == 2'h3;
  a_busy_rise: assert property (go |=> busy) else $error("busy late");
  a_word_len: assert property (go && fast && op == 3'h1 |=> prog[*8] ##[21:25] done)
    else $error("word time");
  a_block_first: assert property (go && fast && op == 3'h2 |=> !data_take[*8])
    else $error("first slot short");
  a_done_fall: assert property ($fell(busy) |-> done) else $error("done missing");
  a_done_pulse: assert property (done |=> !done) else $error("done long");
  a_take_pulse: assert property (data_take |=> !data_take) else $error("take long");
  a_no_mix: assert property (!(prog && erase)) else $error("prog and erase");
  a_mass_kind: assert property (mass |-> erase) else $error("mass not erase");
  a_act_busy: assert property (prog || erase |-> busy) else $error("idle active");
  cover property (go && op == 3'h2);
  cover property (data_take && !more);
  cover property ($fell(mass));
endmodule

// [dv/testbench.sv]
// Self-checking bench for the flash timer
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0d got %0d", n, e, g); end end
bind fpet_seq fpet_seq_asserts #(.DIV_W(DIV_W)) chk (.*);
module testbench;
  logic clk = 0, nrst = 0, src_sel = 0, req = 0, more = 0;
  logic [1:0] src_en = 2'h3;
  logic [5:0] div_val = 6'h0;
  logic [2:0] op = 3'h0;
  logic busy, prog, erase, mass, data_take, done;
  int miscompares = 0, n_tests = 0, cyc = 0, sent = 0, blen = 0, units;
  fpet_seq uut (.clk(clk), .nrst(nrst), .src_en(src_en), .src_sel(src_sel), .div_val(div_val),
    .req(req), .op(op), .more(more), .busy(busy), .prog(prog), .erase(erase), .mass(mass),
    .data_take(data_take), .done(done));
  fpet_flash_model fm (.clk(clk), .data_take(data_take), .units(units));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (data_take) begin
      sent <= sent + 1;
      more <= (sent + 2 < blen);
    end
    if (cyc == 40000) begin
      miscompares++;
      end_of_test();
    end
  end
  function automatic int exp_len(input logic [2:0] o, input int n);
    case (o)
      3'h1: return 30;
      3'h2: return 25 + 18 * (n - 1) + 6;
      3'h3: return 4819;
      3'h4: return 10593;
      default: return 0;
    endcase
  endfunction
  task automatic run(input logic [2:0] o, input int n);
    int c;
    int u;
    logic b;
    c = 0;
    u = units;
    b = 1'b0;
    @(posedge clk);
    req <= 1'b1;
    op <= o;
    more <= (n > 1);
    sent <= 0;
    blen <= n;
    @(posedge clk);
    req <= 1'b0;
    do begin
      @(negedge clk);
      b = (busy === 1'b1);
      if (b) begin
        c++;
        @(posedge clk);
        req <= (c == 3);
        op <= (c == 3) ? 3'h4 : o;
      end
    end while (b && c < 20000);
    `CHK("busy cycles", exp_len(o, n), c)
    `CHK("units", (o == 3'h2) ? n : 0, units - u)
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h9d64e265));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    run(3'h1, 1);
    run(3'h2, 1);
    run(3'h2, 64);
    repeat (3) run(3'h2, $urandom_range(63, 2));
    run(3'h0, 1);
    run(3'h5, 1);
    run(3'h3, 1);
    repeat (2) run(3'h4, 1);
    src_en <= 2'h2;
    src_sel <= 1'b1;
    run(3'h1, 1);
    end_of_test();
  end
endmodule

// [rtl/fpet_defs.svh]
// Timing constants for the flash program and erase timer
`ifndef FPET_DEFS_SVH
`define FPET_DEFS_SVH
`define FPET_WORD_TICKS 14'd30
`define FPET_BLK_FIRST_TICKS 14'd25
`define FPET_BLK_NEXT_TICKS 14'd18
`define FPET_BLK_END_TICKS 14'd6
`define FPET_MASS_TICKS 14'd10593
`define FPET_SEG_TICKS 14'd4819
`define FPET_BLK_MAX 7'd64
`define FPET_DIV_W 6
`endif

// [rtl/fpet_divider.sv]
// Timing generator clock divider with source select
`timescale 1ns/1ps
`include "fpet_defs.svh"
module fpet_divider #(
  parameter int DIV_W = `FPET_DIV_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] src_en,
  input wire logic src_sel,
  input wire logic [DIV_W-1:0] div_val,
  fpet_tick_if.src tk
);
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] next_cnt;
  logic src_pulse;
  logic pulse;
  logic next_pulse;

  // ****************************************
  // Source select and divide
  // ****************************************
  assign src_pulse = src_en[src_sel];
  always_comb begin
    next_cnt = cnt;
    next_pulse = 1'b0;
    if (src_pulse) begin
      if (cnt >= div_val) begin
        next_cnt = '0;
        next_pulse = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
      pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pulse <= next_pulse;
    end
  end
  assign tk.tick = pulse;
endmodule

// [rtl/fpet_pkg.sv]
// Types for the flash program and erase timer
package fpet_pkg;
  typedef enum logic [2:0] {
    FPET_IDLE = 3'b000,
    FPET_WORD = 3'b001,
    FPET_BLK_FIRST = 3'b010,
    FPET_BLK_NEXT = 3'b011,
    FPET_BLK_END = 3'b100,
    FPET_MASS = 3'b101,
    FPET_SEG = 3'b110
  } fpet_state_t;
  typedef enum logic [2:0] {
    FPET_OP_NONE = 3'b000,
    FPET_OP_WORD = 3'b001,
    FPET_OP_BLOCK = 3'b010,
    FPET_OP_SEG = 3'b011,
    FPET_OP_MASS = 3'b100
  } fpet_op_t;
endpackage

// [rtl/fpet_seq.sv]
// Flash program and erase timing sequencer top
// Function
// - A single word or byte write holds program state for 30 timing generator periods.
// - In block write the first byte or word takes 25 timing generator periods.
// - Each further block byte or word, up to 63 more, takes 18 periods.
// - A block write ends with a closing wait of 6 periods before completion.
// - Durations are fixed; mass erase takes 10593 periods and segment erase 4819.
`timescale 1ns/1ps
`include "fpet_defs.svh"
module fpet_seq #(
  parameter int DIV_W = `FPET_DIV_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] src_en,
  input wire logic src_sel,
  input wire logic [DIV_W-1:0] div_val,
  input wire logic req,
  input wire logic [2:0] op,
  input wire logic more,
  output logic busy,
  output logic prog,
  output logic erase,
  output logic mass,
  output logic data_take,
  output logic done
);
  fpet_tick_if tk ();
  fpet_pkg::fpet_state_t state;
  fpet_pkg::fpet_state_t next_state;
  logic [13:0] cnt;
  logic [13:0] next_cnt;
  logic [6:0] nbytes;
  logic [6:0] next_nbytes;
  logic next_take;
  logic next_done;

  fpet_divider #(.DIV_W(DIV_W)) u_div (
    .clk(clk),
    .nrst(nrst),
    .src_en(src_en),
    .src_sel(src_sel),
    .div_val(div_val),
    .tk(tk)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_nbytes = nbytes;
    next_take = 1'b0;
    next_done = 1'b0;
    case (state)
      fpet_pkg::FPET_IDLE: begin
        next_nbytes = 7'd0;
        if (req) begin
          next_cnt = 14'd0;
          case (fpet_pkg::fpet_op_t'(op))
            fpet_pkg::FPET_OP_WORD: next_state = fpet_pkg::FPET_WORD;
            fpet_pkg::FPET_OP_BLOCK: next_state = fpet_pkg::FPET_BLK_FIRST;
            fpet_pkg::FPET_OP_SEG: next_state = fpet_pkg::FPET_SEG;
            fpet_pkg::FPET_OP_MASS: next_state = fpet_pkg::FPET_MASS;
            default: next_state = fpet_pkg::FPET_IDLE;
          endcase
        end
      end
      default: begin
        if (tk.tick) begin
          next_cnt = cnt + 14'd1;
          case (state)
            fpet_pkg::FPET_WORD: begin
              if (next_cnt == `FPET_WORD_TICKS) begin
                next_state = fpet_pkg::FPET_IDLE;
                next_done = 1'b1;
              end
            end
            fpet_pkg::FPET_BLK_FIRST, fpet_pkg::FPET_BLK_NEXT: begin
              if (next_cnt == ((state == fpet_pkg::FPET_BLK_FIRST) ?
                  `FPET_BLK_FIRST_TICKS : `FPET_BLK_NEXT_TICKS)) begin
                next_cnt = 14'd0;
                next_take = 1'b1;
                next_nbytes = nbytes + 7'd1;
                if (more && next_nbytes < `FPET_BLK_MAX) begin
                  next_state = fpet_pkg::FPET_BLK_NEXT;
                end else begin
                  next_state = fpet_pkg::FPET_BLK_END;
                end
              end
            end
            fpet_pkg::FPET_BLK_END: begin
              if (next_cnt == `FPET_BLK_END_TICKS) begin
                next_state = fpet_pkg::FPET_IDLE;
                next_done = 1'b1;
              end
            end
            fpet_pkg::FPET_MASS: begin
              if (next_cnt == `FPET_MASS_TICKS) begin
                next_state = fpet_pkg::FPET_IDLE;
                next_done = 1'b1;
              end
            end
            fpet_pkg::FPET_SEG: begin
              if (next_cnt == `FPET_SEG_TICKS) begin
                next_state = fpet_pkg::FPET_IDLE;
                next_done = 1'b1;
              end
            end
            default: next_state = fpet_pkg::FPET_IDLE;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= fpet_pkg::FPET_IDLE;
      cnt <= 14'd0;
      nbytes <= 7'd0;
      data_take <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      nbytes <= next_nbytes;
      data_take <= next_take;
      done <= next_done;
    end
  end

  // ****************************************
  // Array controls
  // ****************************************
  assign busy = (state != fpet_pkg::FPET_IDLE);
  assign prog = (state == fpet_pkg::FPET_WORD) || (state == fpet_pkg::FPET_BLK_FIRST) ||
                (state == fpet_pkg::FPET_BLK_NEXT);
  assign erase = (state == fpet_pkg::FPET_MASS) || (state == fpet_pkg::FPET_SEG);
  assign mass = (state == fpet_pkg::FPET_MASS);
endmodule

// [rtl/fpet_tick_if.sv]
// Tick link between the timing generator divider and the sequencer
`timescale 1ns/1ps
interface fpet_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface
